// file: logic/pbpc_change_detect.v
// Change detector for the upper four port pins.
// Assumes pin levels already synchronous to clk and strobes one cycle long.
`timescale 1ns/1ps
module pbpc_change_detect #(
  parameter W = 4
) (
  input wire clk,
  input wire resetn,
  input wire warm_reset,
  input wire [W-1:0] pin_level,
  input wire [W-1:0] pin_is_input,
  input wire [W-1:0] chg_en,
  input wire port_access,
  input wire flag_clear,
  output reg [W-1:0] last_read,
  output reg port_change_flag,
  output wire mismatch
);
  wire [W-1:0] diff;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_cmp
      assign diff[i] = chg_en[i] & pin_is_input[i] & (pin_level[i] ^ last_read[i]);
    end
  endgenerate

  assign mismatch = |diff;

  // Only power-on clears this latch; warm resets leave it alone
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_read <= {W{1'b0}};
    end else if (port_access) begin
      last_read <= pin_level;
    end
  end

  // A mismatch keeps setting the flag and wins over a clear.
  // A change landing on a read edge is still caught: the allowed miss never happens.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      port_change_flag <= 1'b0;
    end else if (warm_reset) begin
      port_change_flag <= 1'b0;
    end else if (mismatch) begin
      port_change_flag <= 1'b1;
    end else if (flag_clear) begin
      port_change_flag <= 1'b0;
    end
  end
endmodule // pbpc_change_detect

// file: logic/pbpc_defs.vh
// Constants for the port-B pull-up and change-interrupt block.
// Assumes a single clock domain and the plain register port of pbpc_port.
`ifndef PBPC_DEFS_VH
`define PBPC_DEFS_VH

`define PBPC_ADDR_W 4
`define PBPC_OFF_PORT 4'h0
`define PBPC_OFF_LATCH 4'h1
`define PBPC_OFF_DIR 4'h2
`define PBPC_OFF_ANALOG 4'h3
`define PBPC_OFF_PULLUP 4'h4
`define PBPC_OFF_CHG_EN 4'h5
`define PBPC_OFF_CTRL 4'h6

`define PBPC_CTRL_PU_DIS 0
`define PBPC_CTRL_IRQ_EN 1
`define PBPC_CTRL_FLAG 2

`define PBPC_RST_DIR 8'hff
`define PBPC_RST_LATCH 8'h00
`define PBPC_RST_PULLUP 8'h00
`define PBPC_RST_CHG_EN 4'h0
`define PBPC_RST_PU_DIS 1'b1
`define PBPC_ANALOG_POR 8'h3f
`define PBPC_ANALOG_CFG1 8'h00

`endif

// file: logic/pbpc_port.v
// Port-B pull-ups, change interrupt, analog defaults and pin relocation.
// Assumes inputs synchronous to clk; resetn is the power-on reset,
// warm_reset a synchronous level for external-pin and brown-out resets.
`timescale 1ns/1ps
`include "pbpc_defs.vh"
module pbpc_port #(
  parameter N = 8,
  parameter CHG_LO = 4
) (
  input wire clk,
  input wire resetn,
  input wire warm_reset,
  input wire [`PBPC_ADDR_W-1:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire file_to_file_move,
  output reg [7:0] rdata,
  input wire analog_default_cfg,
  input wire pwm2b_relocate_fuse,
  input wire capture3_relocate_fuse,
  input wire timer3_clk_relocate_fuse,
  input wire capture2_relocate_fuse,
  input wire large_package,
  input wire pwm2_output_b,
  input wire pwm2_output_b_en,
  input wire pwm3_output_a,
  input wire pwm3_output_a_en,
  input wire capture_compare_three,
  input wire capture_compare_three_en,
  input wire capture_compare_two,
  input wire capture_compare_two_en,
  input wire pwm2_output_a,
  input wire pwm2_output_a_en,
  input wire timer3_default_pin,
  input wire [N-1:0] pin_in,
  output reg [N-1:0] pin_out,
  output reg [N-1:0] pin_oe_n,
  output reg [N-1:0] pullup_on,
  output reg portc_bit0,
  output reg portc_bit0_oe_n,
  output reg portc_bit6,
  output reg portc_bit6_oe_n,
  output reg porte_bit0,
  output reg porte_bit0_oe_n,
  output reg timer3_clock_in,
  output reg capture_three_in,
  output reg capture_two_in,
  output reg change_irq,
  output reg wake
);
  localparam CW = N - CHG_LO;
  localparam B3 = 3;
  localparam B5 = 5;

  reg [N-1:0] port_output_latch;
  reg [N-1:0] port_direction;
  reg [N-1:0] port_analog_select;
  reg [N-1:0] pullup_enable_bits;
  reg [CW-1:0] change_irq_enable_bits;
  reg global_pullup_disable;
  reg port_change_irq_enable;
  reg defaults_loaded;

  wire [N-1:0] digital_in;
  wire port_access;
  wire flag_clear;
  wire port_change_flag;
  wire c3_home;
  wire c2_home;
  wire p2b_home;
  wire t3_home;
  wire wr_ctrl;
  wire [7:0] ctrl_view;
  reg [N-1:0] next_pin_out;
  reg [7:0] next_rdata;

  assign c3_home = capture3_relocate_fuse;
  assign c2_home = capture2_relocate_fuse;
  assign p2b_home = pwm2b_relocate_fuse;
  assign t3_home = timer3_clk_relocate_fuse;

  // Analog-selected pins read zero on the digital path
  assign digital_in = pin_in & ~port_analog_select;

  // File-to-file moves touch the port without ending the mismatch
  assign port_access = (rd | wr) & (addr == `PBPC_OFF_PORT) & ~file_to_file_move;
  assign wr_ctrl = wr & (addr == `PBPC_OFF_CTRL);
  assign flag_clear = wr_ctrl & ~wdata[`PBPC_CTRL_FLAG];

  assign ctrl_view = {5'h00, port_change_flag, port_change_irq_enable, global_pullup_disable};

  pbpc_change_detect #(
    .W(CW)
  ) u_detect (
    .clk(clk),
    .resetn(resetn),
    .warm_reset(warm_reset),
    .pin_level(digital_in[N-1:CHG_LO]),
    .pin_is_input(port_direction[N-1:CHG_LO]),
    .chg_en(change_irq_enable_bits),
    .port_access(port_access),
    .flag_clear(flag_clear),
    .last_read(),
    .port_change_flag(port_change_flag),
    .mismatch()
  );

  // Software-visible registers; defaults reload on any reset
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      port_output_latch <= `PBPC_RST_LATCH;
      port_direction <= `PBPC_RST_DIR;
      pullup_enable_bits <= `PBPC_RST_PULLUP;
      change_irq_enable_bits <= `PBPC_RST_CHG_EN;
      global_pullup_disable <= `PBPC_RST_PU_DIS;
      port_change_irq_enable <= 1'b0;
    end else if (warm_reset) begin
      port_output_latch <= `PBPC_RST_LATCH;
      port_direction <= `PBPC_RST_DIR;
      pullup_enable_bits <= `PBPC_RST_PULLUP;
      change_irq_enable_bits <= `PBPC_RST_CHG_EN;
      global_pullup_disable <= `PBPC_RST_PU_DIS;
      port_change_irq_enable <= 1'b0;
    end else if (wr) begin
      case (addr)
        `PBPC_OFF_PORT: begin
          port_output_latch <= wdata[N-1:0];
        end
        `PBPC_OFF_LATCH: begin
          port_output_latch <= wdata[N-1:0];
        end
        `PBPC_OFF_DIR: begin
          port_direction <= wdata[N-1:0];
        end
        `PBPC_OFF_PULLUP: begin
          pullup_enable_bits <= wdata[N-1:0];
        end
        `PBPC_OFF_CHG_EN: begin
          change_irq_enable_bits <= wdata[N-1:CHG_LO];
        end
        `PBPC_OFF_CTRL: begin
          global_pullup_disable <= wdata[`PBPC_CTRL_PU_DIS];
          port_change_irq_enable <= wdata[`PBPC_CTRL_IRQ_EN];
        end
        default: begin
          port_output_latch <= port_output_latch;
        end
      endcase
    end
  end

  // Analog select: constant under power-on reset, configuration applied after its release and during warm reset
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      port_analog_select <= `PBPC_ANALOG_POR;
      defaults_loaded <= 1'b0;
    end else if (!defaults_loaded || warm_reset) begin
      port_analog_select <= analog_default_cfg ? `PBPC_ANALOG_CFG1 : `PBPC_ANALOG_POR;
      defaults_loaded <= 1'b1;
    end else if (wr && addr == `PBPC_OFF_ANALOG) begin
      port_analog_select <= wdata[N-1:0];
    end
  end

  // Pin data: peripherals by priority, else the output latch
  always @* begin
    next_pin_out = port_output_latch;
    if (!c2_home && capture_compare_two_en) begin
      next_pin_out[B3] = capture_compare_two;
    end else if (!c2_home && pwm2_output_a_en) begin
      next_pin_out[B3] = pwm2_output_a;
    end
    if (c3_home && capture_compare_three_en) begin
      next_pin_out[B5] = capture_compare_three;
    end else if (c3_home && pwm3_output_a_en) begin
      next_pin_out[B5] = pwm3_output_a;
    end else if (p2b_home && pwm2_output_b_en) begin
      next_pin_out[B5] = pwm2_output_b;
    end
  end

  // Register read mux; port reads return pin levels
  always @* begin
    next_rdata = 8'h00;
    case (addr)
      `PBPC_OFF_PORT: next_rdata = digital_in;
      `PBPC_OFF_LATCH: next_rdata = port_output_latch;
      `PBPC_OFF_DIR: next_rdata = port_direction;
      `PBPC_OFF_ANALOG: next_rdata = port_analog_select;
      `PBPC_OFF_PULLUP: next_rdata = pullup_enable_bits;
      `PBPC_OFF_CHG_EN: next_rdata = {change_irq_enable_bits, {CHG_LO{1'b0}}};
      `PBPC_OFF_CTRL: next_rdata = ctrl_view;
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

  // Pin drivers and pull-ups; analog select leaves outputs alone
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_out <= {N{1'b0}};
      pin_oe_n <= {N{1'b1}};
      pullup_on <= {N{1'b0}};
    end else begin
      pin_out <= next_pin_out;
      pin_oe_n <= port_direction;
      pullup_on <= pullup_enable_bits & {N{~global_pullup_disable}} & port_direction;
    end
  end

  // Relocated peripheral pins and routed inputs
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      portc_bit0 <= 1'b0;
      portc_bit0_oe_n <= 1'b1;
      portc_bit6 <= 1'b0;
      portc_bit6_oe_n <= 1'b1;
      porte_bit0 <= 1'b0;
      porte_bit0_oe_n <= 1'b1;
      timer3_clock_in <= 1'b0;
      capture_three_in <= 1'b0;
      capture_two_in <= 1'b0;
    end else begin
      portc_bit0 <= pwm2_output_b;
      portc_bit0_oe_n <= ~(~p2b_home & pwm2_output_b_en);
      portc_bit6 <= capture_compare_three_en ? capture_compare_three : pwm3_output_a;
      portc_bit6_oe_n <= ~(~c3_home & ~large_package & (capture_compare_three_en | pwm3_output_a_en));
      porte_bit0 <= capture_compare_three_en ? capture_compare_three : pwm3_output_a;
      porte_bit0_oe_n <= ~(~c3_home & large_package & (capture_compare_three_en | pwm3_output_a_en));
      timer3_clock_in <= t3_home ? timer3_default_pin : digital_in[B5];
      capture_three_in <= digital_in[B5];
      capture_two_in <= digital_in[B3];
    end
  end

  // Interrupt and wake request, gated by the global change enable
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      change_irq <= 1'b0;
      wake <= 1'b0;
    end else begin
      change_irq <= port_change_flag & port_change_irq_enable;
      wake <= port_change_flag & port_change_irq_enable;
    end
  end
endmodule // pbpc_port

// file: verification/pbpc_pins_model.sv
// Far side of the port pins: device drive, outside drive, pull-up or float.
// Assumes the bench gives the outside drive level and its enable per pin.
`timescale 1ns/1ps
module pbpc_pins_model (
  input logic clk,
  input logic [7:0] pin_out,
  input logic [7:0] pin_oe_n,
  input logic [7:0] pullup_on,
  input logic [7:0] ext_val,
  input logic [7:0] ext_en,
  output logic [7:0] pin_in
);
  logic [7:0] last = 8'h00;
  always @(posedge clk) last <= pin_in;
  // Floating pins toggle so that no stale level is read
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
    | (pin_oe_n & ~ext_en & (pullup_on | ~last));
endmodule // pbpc_pins_model

// file: verification/pbpc_port_bench.sv
// Self-checking bench for pbpc_port with the pin model and checker.
// Assumes pbpc_port, pbpc_pins_model and pbpc_properties are compiled first.
`timescale 1ns/1ps
module pbpc_port_bench;
  logic clk = 0, resetn = 0, warm_reset = 0, wr = 0, rd = 0, file_to_file_move = 0;
  logic analog_default_cfg = 0, large_package = 0, timer3_default_pin = 0;
  logic [3:0] addr = 0, fuse = 4'hf;
  logic [9:0] per = 0;
  logic [7:0] wdata = 0, ext_val = 0, ext_en = 0, d, rdata, pin_in, pin_out, pin_oe_n, pullup_on;
  logic portc_bit0, portc_bit0_oe_n, portc_bit6, portc_bit6_oe_n, porte_bit0, porte_bit0_oe_n;
  logic timer3_clock_in, capture_three_in, capture_two_in, change_irq, wake;
  wire pwm2b_relocate_fuse = fuse[0], capture3_relocate_fuse = fuse[1];
  wire timer3_clk_relocate_fuse = fuse[2], capture2_relocate_fuse = fuse[3];
  wire pwm2_output_b = per[0], pwm2_output_b_en = per[1], pwm3_output_a = per[2];
  wire pwm3_output_a_en = per[3], capture_compare_three = per[4];
  wire capture_compare_three_en = per[5], capture_compare_two = per[6];
  wire capture_compare_two_en = per[7], pwm2_output_a = per[8], pwm2_output_a_en = per[9];
  int errors = 0, checked = 0, cyc = 0;
  logic [19:0] rows [7] = '{{4'h1, 8'ha5, 8'ha5}, {4'h4, 8'h3c, 8'h3c}, {4'h5, 8'hf0, 8'hf0},
    {4'h3, 8'h00, 8'h00}, {4'h2, 8'h0f, 8'h0f}, {4'h2, 8'hff, 8'hff}, {4'hf, 8'h55, 8'h00}};
  pbpc_port dut_u (.*);
  pbpc_pins_model pins_u (.*);
  initial forever #50 clk = ~clk;
  task finish_test;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      finish_test;
    end
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task w(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task r(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 d = rdata;
  endtask
  task idle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task pins(input logic [7:0] v);
    @(posedge clk);
    ext_val <= v;
    ext_en <= 8'hff;
    idle;
  endtask
  task warm;
    @(posedge clk);
    warm_reset <= 1;
    @(posedge clk);
    warm_reset <= 0;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1;
    repeat (2) @(posedge clk);
    r(4'h2); chk(d, 8'hff);
    r(4'h3); chk(d, 8'h3f);
    r(4'h6); chk(d, 8'h01);
    chk(pullup_on, 8'h00);
    $display("reset test done");
    foreach (rows[i]) begin
      w(rows[i][19:16], rows[i][15:8]);
      r(rows[i][19:16]);
      chk(d, rows[i][7:0]);
    end
    $display("register table done");
    w(4'h4, 8'hff); w(4'h6, 8'h00); idle;
    chk(pullup_on, 8'hff);
    w(4'h6, 8'h01); idle;
    chk(pullup_on, 8'h00);
    w(4'h6, 8'h00); w(4'h2, 8'h0f); idle;
    chk(pullup_on, 8'h0f);
    w(4'h1, 8'ha5); idle;
    chk(pin_out & ~pin_oe_n, 8'ha0);
    r(4'h0); chk(d, 8'haf);
    w(4'h2, 8'hff); w(4'h3, 8'h3f); pins(8'h96);
    r(4'h0); chk(d, 8'h80);
    $display("pull-up and read test done");
    w(4'h3, 8'h00); w(4'h6, 8'h02); r(4'h0); idle; w(4'h6, 8'h02); idle;
    chk({7'h0, change_irq}, 8'h00);
    pins(8'h86);
    chk({6'h0, change_irq, wake}, 8'h03);
    w(4'h6, 8'h02); idle;
    chk({7'h0, change_irq}, 8'h01);
    file_to_file_move <= 1; r(4'h0); file_to_file_move <= 0; w(4'h6, 8'h02); idle;
    chk({7'h0, change_irq}, 8'h01);
    r(4'h0); idle; w(4'h6, 8'h02); idle;
    chk({7'h0, change_irq}, 8'h00);
    pins(8'h87);
    chk({7'h0, change_irq}, 8'h00);
    w(4'h1, 8'h10); w(4'h2, 8'hef); idle;
    chk({7'h0, change_irq}, 8'h00);
    w(4'h2, 8'hff); w(4'h6, 8'h00); pins(8'h07);
    chk({7'h0, change_irq}, 8'h00);
    w(4'h6, 8'h02); idle;
    chk({7'h0, change_irq}, 8'h01);
    $display("change test done");
    warm; w(4'h5, 8'hf0); w(4'h6, 8'h02); idle;
    chk({7'h0, change_irq}, 8'h01);
    analog_default_cfg <= 1; warm; r(4'h3);
    chk(d, 8'h00);
    $display("warm reset test done");
    fuse <= 4'h0; large_package <= 1; per <= 10'h3ff; pins(8'hb7);
    chk({6'h0, portc_bit0, porte_bit0}, 8'h03);
    chk({6'h0, timer3_clock_in, capture_two_in}, 8'h02);
    chk({3'h0, portc_bit0_oe_n, portc_bit6_oe_n, porte_bit0_oe_n, capture_three_in, portc_bit6}, 8'h0b);
    chk({6'h0, pin_out[5], pin_out[3]}, 8'h01);
    per <= 10'h3ee; idle;
    chk({6'h0, portc_bit0, porte_bit0}, 8'h00);
    large_package <= 0; idle;
    chk({6'h0, portc_bit6_oe_n, porte_bit0_oe_n}, 8'h01);
    fuse <= 4'hf; per <= 10'h03a; timer3_default_pin <= 1; w(4'h2, 8'hdf); idle;
    chk({7'h0, pin_out[5]}, 8'h01);
    chk({7'h0, timer3_clock_in}, 8'h01);
    $display("relocation test done");
    finish_test;
  end
endmodule // pbpc_port_bench
bind pbpc_port pbpc_properties chk_u (.*);

// file: verification/pbpc_properties.sv
// Checker for pbpc_port: pull-ups, pin drive, change flag and relocation.
// Assumes it is bound to pbpc_port and sees only that module's ports.
`timescale 1ns/1ps
`include "pbpc_defs.vh"
module pbpc_properties (
  input logic clk,
  input logic resetn,
  input logic warm_reset,
  input logic [`PBPC_ADDR_W-1:0] addr,
  input logic [7:0] wdata,
  input logic wr,
  input logic [7:0] pin_out,
  input logic [7:0] pin_oe_n,
  input logic [7:0] pullup_on,
  input logic change_irq,
  input logic wake,
  input logic pwm2b_relocate_fuse,
  input logic pwm2_output_b,
  input logic pwm2_output_b_en,
  input logic portc_bit0,
  input logic capture3_relocate_fuse,
  input logic large_package,
  input logic capture_compare_three,
  input logic capture_compare_three_en,
  input logic porte_bit0
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire ctrl_wr = wr && addr == `PBPC_OFF_CTRL;
  property p_pu_dir; (pullup_on & ~pin_oe_n) == 8'h00; endproperty
  a_pu_dir: assert property (p_pu_dir) else $error("pull-up on driven pin");
  property p_pu_dis; ctrl_wr && wdata[0] |-> ##2 pullup_on == 8'h00; endproperty
  a_pu_dis: assert property (p_pu_dis) else $error("pull-up kept on");
  property p_pu_por; $rose(resetn) |-> (pullup_on == 8'h00)[*2]; endproperty
  a_pu_por: assert property (p_pu_por) else $error("pull-up on after reset");
  property p_wake; wake == change_irq; endproperty
  a_wake: assert property (p_wake) else $error("wake differs from irq");
  property p_latch;
    wr && addr == `PBPC_OFF_LATCH |-> ##2 ((pin_out ^ $past(wdata, 2)) & ~pin_oe_n & 8'hd7) == 8'h00;
  endproperty
  a_latch: assert property (p_latch) else $error("pin not driving latch");
  property p_flag_hold; $fell(change_irq) |-> $past(ctrl_wr || warm_reset, 2); endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped alone");
  property p_pwm2b;
    ((!pwm2b_relocate_fuse && pwm2_output_b_en && $stable(pwm2_output_b))[*3])
      |-> portc_bit0 == pwm2_output_b;
  endproperty
  a_pwm2b: assert property (p_pwm2b) else $error("pwm output not relocated");
  property p_cap3;
    ((!capture3_relocate_fuse && large_package && capture_compare_three_en
      && $stable(capture_compare_three))[*3]) |-> porte_bit0 == capture_compare_three;
  endproperty
  a_cap3: assert property (p_cap3) else $error("capture not relocated");
endmodule // pbpc_properties
